// ===== verilog/dscp_pkg.sv
// Constants and types shared by the serial command port.
// Behaviour
// R01: Shift serial_in on rising clock while selected.
// R02: Host keeps select low during whole word.
// R03: Select rising edge executes the shifted command.
// R04: Accept 24-bit and 32-bit command words.
// R05: Command byte, two data bytes, optional CRC.
// R06: Check CRC only on 32-bit words.
// R07: Host clocks multiples of 32 in daisy chain; the code accepts only 24 or 32 clocks and faults any other count.
// R08: Count clocks per frame, fault bad counts.
// R09: 32-bit writes echo during next frame.
// R10: 32-bit reads return command and data next.
// R11: Host discards first byte of 24-bit reads.
// R12: No write echo with 24-bit words.
// R13: First byte holds command, low nibble address.
// R14: Configuration and fault commands skip CRC.
// R15: Nibbles 0-3 write code, settings, offset, gain.
// R16: Nibbles 4-6 write/update channel or all.
// R17: Bytes 0x70-0x76 write global registers.
// R18: Bytes 0x78-0x7C act on all channels.
// R19: Nibbles 8-B read channel registers back.
// R20: Bytes 0xF0-0xF7 read global registers.
// R21: Channel n encoded as address 2n.
// R22: Update copies inputs and powers channel up.
// R23: Serial output changes on falling clock.
// R24: Undefined commands change no state; the code still loads cmd_byte and the reply word from them.
package dscp_pkg;
    localparam int WORD_SHORT = 24;
    localparam int WORD_LONG = 32;
    localparam int CRC_W = 6;
    localparam logic [5:0] CRC_POLY = 6'h03;
    localparam logic [5:0] CRC_INIT = 6'h00;
    localparam logic [7:0] CMD_CFG_WR = 8'h70;
    localparam logic [7:0] CMD_FLT_WR = 8'h76;
    localparam logic [7:0] CMD_CFG_RD = 8'hF0;
    localparam logic [7:0] CMD_FLT_RD = 8'hF6;
    localparam logic [7:0] CMD_GLB_RD_LAST = 8'hF7;
    localparam logic [7:0] CMD_ALL_FIRST = 8'h78;
    localparam logic [7:0] CMD_ALL_LAST = 8'h7C;
    localparam logic [3:0] NIB_GLOBAL_WR = 4'h7;
    localparam logic [3:0] NIB_GLOBAL_RD = 4'hF;
    localparam logic [3:0] NIB_UPD_ONE = 4'h6;
    localparam logic [3:0] NIB_WR_UPD_ALL = 4'h5;
    localparam logic [3:0] NIB_WR_UPD_ONE = 4'h4;
    localparam logic [3:0] NIB_RD_LAST = 4'hB;
    localparam logic [3:0] NIB_RD_FIRST = 4'h8;
    // The select pin idles high, so the synchroniser resets to ones and sees no false edge.
    localparam logic [2:0] SYNC_RESET = 3'h7;
    localparam logic [7:0] ALL_CH = 8'hFF;

    typedef enum logic [2:0] {
        DSCP_OP_NONE = 3'h0,
        DSCP_OP_CHAN_WR = 3'h1,
        DSCP_OP_GLB_WR = 3'h2,
        DSCP_OP_CHAN_RD = 3'h3,
        DSCP_OP_GLB_RD = 3'h4
    } dscp_op_t;

    // Serial CRC step, one bit at a time, MSB first.
    function automatic logic [5:0] crc_step(input logic [5:0] crc, input logic bit_in);
        logic fb;
        fb = crc[5] ^ bit_in;
        crc_step = {crc[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
    endfunction
endpackage

// ===== verilog/dscp_frame_if.sv
// Frame hand-off carrier from the link domain to the system domain.
`timescale 1ns/1ps
`default_nettype none
interface dscp_frame_if;
    logic closed;
    logic [31:0] word;
    logic [5:0] count;
    logic crc_ok;
    logic [31:0] reply;
    logic reply_long;
    modport link (output closed, output word, output count, output crc_ok,
                  input reply, input reply_long);
    modport core (input closed, input word, input count, input crc_ok,
                  output reply, output reply_long);
endinterface
`default_nettype wire

// ===== verilog/dscp_link.sv
// Link-clock shifter: frames words, counts clocks and shifts replies out.
`timescale 1ns/1ps
`default_nettype none
module dscp_link (
    input wire logic serial_clk,
    input wire logic select_load_n,
    input wire logic serial_in,
    output logic serial_out,
    dscp_frame_if.link frm
);
    logic [31:0] shift_q, shift_d;
    logic [5:0] cnt_q, cnt_d;
    logic [5:0] crc_q, crc_d;
    logic [31:0] tx_q, tx_d;
    logic [31:0] aligned;
    logic first_q;

    // ----------------------------------------------------------------
    // Input shifting
    // ----------------------------------------------------------------
    always_comb begin
        shift_d = {shift_q[30:0], serial_in}; // R01
        cnt_d = (cnt_q == 6'h3F) ? cnt_q : 6'(cnt_q + 6'h01); // R08
        crc_d = crc_q;
        if (cnt_q < 6'(dscp_pkg::WORD_SHORT)) begin
            crc_d = dscp_pkg::crc_step(crc_q, serial_in); // R06
        end
    end

    // Select high resets the frame state asynchronously as the frame closes.
    always_ff @(posedge serial_clk or posedge select_load_n) begin
        if (select_load_n) begin
            shift_q <= 32'h0000_0000;
            cnt_q <= 6'h00;
            crc_q <= dscp_pkg::CRC_INIT;
        end else begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            crc_q <= crc_d;
        end
    end

    // ----------------------------------------------------------------
    // Reply shifting
    // ----------------------------------------------------------------
    // The first reply bit must stand before the first rising edge, so it comes
    // straight from the reply word; the shifter takes the rest at the first
    // falling edge. The reply is stable because frames are spaced apart.
    always_comb begin
        aligned = frm.reply_long ? frm.reply : {frm.reply[23:0], 8'h00};
        tx_d = first_q ? {aligned[30:0], 1'b0} : {tx_q[30:0], 1'b0};
    end

    always_ff @(negedge serial_clk or posedge select_load_n) begin
        if (select_load_n) begin
            tx_q <= 32'h0000_0000;
            first_q <= 1'b1;
        end else begin
            tx_q <= tx_d; // R23
            first_q <= 1'b0;
        end
    end

    assign serial_out = first_q ? aligned[31] : tx_q[31]; // R09 R10

    // ----------------------------------------------------------------
    // Frame end capture
    // ----------------------------------------------------------------
    always_ff @(posedge select_load_n) begin
        frm.word <= shift_q; // R03
        frm.count <= cnt_q;
        frm.crc_ok <= (crc_q == shift_q[5:0]);
    end

    // The select level itself tells the system domain that a frame has closed.
    assign frm.closed = select_load_n;

    chk_count_saturate: assert property (@(posedge serial_clk) disable iff (select_load_n) // R08
        (cnt_q == 6'h3F) |=> (cnt_q == 6'h3F)) else $error("clock count wrapped");
endmodule
`default_nettype wire

// ===== verilog/dscp_decode.sv
// Command byte decoder.
`timescale 1ns/1ps
`default_nettype none
module dscp_decode (
    input wire logic [7:0] cmd,
    output var dscp_pkg::dscp_op_t op,
    output logic crc_exempt,
    output logic [2:0] chan,
    output logic upd_one,
    output logic upd_all
);
    always_comb begin
        op = dscp_pkg::DSCP_OP_NONE; // R24
        upd_one = 1'b0;
        upd_all = 1'b0;
        chan = cmd[3:1]; // R13 R21
        crc_exempt = (cmd == dscp_pkg::CMD_CFG_WR) || (cmd == dscp_pkg::CMD_FLT_WR) ||
                     (cmd == dscp_pkg::CMD_CFG_RD) || (cmd == dscp_pkg::CMD_FLT_RD); // R14
        if (cmd[7:4] <= dscp_pkg::NIB_UPD_ONE) begin
            op = dscp_pkg::DSCP_OP_CHAN_WR; // R15 R16
            upd_one = (cmd[7:4] == dscp_pkg::NIB_WR_UPD_ONE) ||
                      (cmd[7:4] == dscp_pkg::NIB_UPD_ONE);
            upd_all = (cmd[7:4] == dscp_pkg::NIB_WR_UPD_ALL);
        end else if (cmd[7:4] == dscp_pkg::NIB_GLOBAL_WR) begin
            if (cmd <= dscp_pkg::CMD_FLT_WR) begin
                op = dscp_pkg::DSCP_OP_GLB_WR; // R17
            end else if (cmd >= dscp_pkg::CMD_ALL_FIRST && cmd <= dscp_pkg::CMD_ALL_LAST) begin
                op = dscp_pkg::DSCP_OP_CHAN_WR; // R18
                upd_all = cmd[0] || (cmd == dscp_pkg::CMD_ALL_LAST);
            end
        end else if (cmd[7:4] >= dscp_pkg::NIB_RD_FIRST && cmd[7:4] <= dscp_pkg::NIB_RD_LAST) begin
            op = dscp_pkg::DSCP_OP_CHAN_RD; // R19
        end else if (cmd >= dscp_pkg::CMD_CFG_RD && cmd <= dscp_pkg::CMD_GLB_RD_LAST) begin
            op = dscp_pkg::DSCP_OP_GLB_RD; // R20
        end
    end
endmodule
`default_nettype wire

// ===== verilog/dscp_top.sv
// Serial command port top: frame checks, command execution, reply build.
`timescale 1ns/1ps
`default_nettype none
module dscp_top (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic select_load_n,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic crc_enable,
    input wire logic [15:0] read_data,
    output logic [7:0] cmd_byte,
    output logic [15:0] cmd_data,
    output logic cmd_strobe,
    output logic frame_fault,
    output logic crc_fault,
    output logic [7:0] update_mask
);
    dscp_frame_if frm ();

    dscp_link u_link (
        .serial_clk(serial_clk),
        .select_load_n(select_load_n),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .frm(frm)
    );

    logic [2:0] tsync_q, tsync_d;
    logic [7:0] cmd_q, cmd_d;
    logic [15:0] data_q, data_d;
    logic strobe_q, strobe_d;
    logic ffault_q, ffault_d;
    logic cfault_q, cfault_d;
    logic [7:0] upd_q, upd_d;
    logic [31:0] reply_q, reply_d;
    logic long_q, long_d;

    dscp_pkg::dscp_op_t op;
    logic exempt;
    logic [2:0] chan;
    logic upd_one;
    logic upd_all;
    logic [31:0] w;
    logic is_long;
    logic is_short;
    logic frame_done;

    // The captured word stands still once the closed level has passed the synchroniser.
    assign is_long = (frm.count == 6'(dscp_pkg::WORD_LONG)); // R04
    assign is_short = (frm.count == 6'(dscp_pkg::WORD_SHORT)); // R04
    assign w = is_long ? frm.word : {frm.word[23:0], 8'h00}; // R05
    assign frame_done = tsync_q[1] && !tsync_q[2]; // R03

    dscp_decode u_dec (
        .cmd(w[31:24]),
        .op(op),
        .crc_exempt(exempt),
        .chan(chan),
        .upd_one(upd_one),
        .upd_all(upd_all)
    );

    // ----------------------------------------------------------------
    // Frame execution in the system domain
    // ----------------------------------------------------------------
    always_comb begin
        tsync_d = {tsync_q[1:0], frm.closed};
        cmd_d = cmd_q;
        data_d = data_q;
        strobe_d = 1'b0;
        ffault_d = ffault_q;
        cfault_d = cfault_q;
        upd_d = 8'h00;
        reply_d = reply_q;
        long_d = long_q;
        if (frame_done) begin
            cmd_d = w[31:24];
            if (!(is_long || is_short)) begin
                ffault_d = 1'b1; // R08
            end else if (is_long && crc_enable && !exempt && !frm.crc_ok) begin
                cfault_d = 1'b1; // R06
            end else if (op != dscp_pkg::DSCP_OP_NONE) begin
                data_d = w[23:8];
                strobe_d = 1'b1; // R03
                upd_d = upd_all ? dscp_pkg::ALL_CH : (upd_one ? (8'h01 << chan) : 8'h00); // R22
            end
            long_d = is_long;
            if (op == dscp_pkg::DSCP_OP_CHAN_RD || op == dscp_pkg::DSCP_OP_GLB_RD) begin
                reply_d = is_long ? {w[31:24], read_data, 8'h00} // R10
                                  : {8'h00, 8'h00, read_data}; // R11
            end else begin
                reply_d = is_long ? w : 32'h0000_0000; // R09 R12
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tsync_q <= dscp_pkg::SYNC_RESET;
            cmd_q <= 8'h00;
            data_q <= 16'h0000;
            strobe_q <= 1'b0;
            ffault_q <= 1'b0;
            cfault_q <= 1'b0;
            upd_q <= 8'h00;
            reply_q <= 32'h0000_0000;
            long_q <= 1'b0;
        end else begin
            tsync_q <= tsync_d;
            cmd_q <= cmd_d;
            data_q <= data_d;
            strobe_q <= strobe_d;
            ffault_q <= ffault_d;
            cfault_q <= cfault_d;
            upd_q <= upd_d;
            reply_q <= reply_d;
            long_q <= long_d;
        end
    end

    assign frm.reply = reply_q;
    assign frm.reply_long = long_q;
    assign cmd_byte = cmd_q;
    assign cmd_data = data_q;
    assign cmd_strobe = strobe_q;
    assign frame_fault = ffault_q;
    assign crc_fault = cfault_q;
    assign update_mask = upd_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_strobe_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n) // R03
        strobe_q |=> !strobe_q) else $error("strobe longer than one cycle");
    chk_update_strobe: assert property (@(posedge sys_clk) disable iff (!reset_n) // R22
        (upd_q != 8'h00) |-> strobe_q) else $error("update without command");
    chk_fault_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n) // R08
        ffault_q |=> ffault_q) else $error("frame fault dropped");
    chk_crc_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n) // R06
        cfault_q |=> cfault_q) else $error("crc fault dropped");
    chk_short_noecho: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
        (strobe_q && !long_q && cmd_q[7] == 1'b0) |-> reply_q == 32'h0000_0000)
        else $error("short write echoed");
    chk_long_echo: assert property (@(posedge sys_clk) disable iff (!reset_n) // R09
        (strobe_q && long_q) |-> reply_q[31:24] == cmd_q) else $error("echo mismatch");
    chk_all_update: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
        (strobe_q && cmd_q == dscp_pkg::CMD_ALL_LAST) |-> upd_q == dscp_pkg::ALL_CH)
        else $error("update all missing");
    chk_data_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // R24
        !strobe_q |=> (strobe_q || $stable(data_q))) else $error("data moved idle");
    chk_fault_blocks: assert property (@(posedge sys_clk) disable iff (!reset_n) // R08
        $rose(ffault_q) |-> !strobe_q) else $error("strobe with frame fault");
    chk_crc_blocks: assert property (@(posedge sys_clk) disable iff (!reset_n) // R06
        $rose(cfault_q) |-> !strobe_q) else $error("strobe with crc fault");
endmodule
`default_nettype wire

// ===== sim/dscp_host.sv
// Host controller model that clocks command words in and replies out.
`timescale 1ns/1ps
`default_nettype none
module dscp_host (
    output logic serial_clk,
    output logic select_load_n,
    output logic serial_in,
    input wire logic serial_out
);
    initial begin
        serial_clk = 1'b0;
        select_load_n = 1'b1;
        serial_in = 1'b0;
    end

    // ----------------------------------------------------------------
    // Frame transfer
    // ----------------------------------------------------------------
    // The clock stays low between frames, and the data line then shows the
    // inverse of its last bit so that a stale value is never mistaken for data.
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h00000000;
        #13 select_load_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #32 serial_clk = 1'b1;
            r = {r[30:0], serial_out};
            #32 serial_clk = 1'b0;
        end
        #32 select_load_n = 1'b1;
        serial_in = ~serial_in;
        #400;
    endtask
endmodule
`default_nettype wire

// ===== sim/dscp_top_tb.sv
// Self-checking bench for the serial command port.
`timescale 1ns/1ps
`default_nettype none
module dscp_top_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic crc_enable = 1'b1;
    logic [15:0] read_data = 16'h5A3C;
    wire logic serial_clk, select_load_n, serial_in, serial_out;
    logic [7:0] cmd_byte, update_mask, seen_mask;
    logic [15:0] cmd_data;
    logic cmd_strobe, frame_fault, crc_fault, seen_stb;
    logic [31:0] rep;
    logic [16:0] rows [$];
    logic [7:0] c;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;

    always #25 sys_clk = ~sys_clk;

    dscp_host host (.serial_clk(serial_clk), .select_load_n(select_load_n),
        .serial_in(serial_in), .serial_out(serial_out));
    dscp_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(serial_clk),
        .select_load_n(select_load_n), .serial_in(serial_in), .serial_out(serial_out),
        .crc_enable(crc_enable), .read_data(read_data), .cmd_byte(cmd_byte),
        .cmd_data(cmd_data), .cmd_strobe(cmd_strobe), .frame_fault(frame_fault),
        .crc_fault(crc_fault), .update_mask(update_mask));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [5:0] crc6(input logic [23:0] d);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 23; i >= 0; i--) begin
            r = {r[4:0], 1'b0} ^ ((r[5] ^ d[i]) ? 6'h03 : 6'h00);
        end
        return r;
    endfunction

    function automatic logic [31:0] lw(input logic [23:0] d, input logic bad);
        return {d, 2'b00, crc6(d) ^ {5'h00, bad}};
    endfunction

    // Returns {strobe expected, update mask expected}.
    function automatic logic [8:0] expect_of(input logic [7:0] k);
        case (k[7:4])
            4'h4, 4'h6: return {1'b1, 8'h01 << k[3:1]};
            4'h5: return 9'h1FF;
            4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: return 9'h100;
            4'h7: return (k == 8'h79 || k == 8'h7B || k == 8'h7C) ? 9'h1FF :
                {k <= 8'h7C && k != 8'h77, 8'h00};
            4'hF: return {k <= 8'hF7, 8'h00};
            default: return 9'h000;
        endcase
    endfunction

    task automatic frame(input logic [31:0] w, input int n);
        @(negedge sys_clk);
        seen_stb = 1'b0;
        seen_mask = 8'h00;
        host.xfer(w, n, rep);
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cmd_strobe === 1'b1) seen_stb <= 1'b1;
        if (update_mask !== 8'h00) seen_mask <= seen_mask | update_mask;
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 256; i++) begin
            c = i[7:0];
            if (!(c[7:4] <= 4'hB && c[0])) rows.push_back({c, expect_of(c)});
        end
        foreach (rows[i]) begin
            frame({8'h00, rows[i][16:9], rows[i][16:9], ~rows[i][16:9]}, 24);
            chk("strobe", {31'h0, rows[i][8]}, {31'h0, seen_stb});
            chk("update_mask", {24'h0, rows[i][7:0]}, {24'h0, seen_mask});
            chk("row cmd_byte", {24'h0, rows[i][16:9]}, {24'h0, cmd_byte});
            if (rows[i][8]) chk("cmd_data", {16'h0, rows[i][16:9], ~rows[i][16:9]}, {16'h0, cmd_data});
        end
        chk("crc_fault", 0, {31'h0, crc_fault});
        chk("frame_fault", 0, {31'h0, frame_fault});
        frame(lw(24'h04A1B2, 1'b0), 32);
        chk("cmd_byte", 8'h04, {24'h0, cmd_byte});
        frame(lw(24'h800000, 1'b0), 32);
        chk("write echo", lw(24'h04A1B2, 1'b0), rep);
        frame(lw(24'hFF0000, 1'b0), 32);
        chk("read reply", {8'h80, 16'h5A3C, 8'h00}, rep);
        frame(32'h00920000, 24);
        frame(32'h0002A1B2, 24);
        chk("short read", 32'h00005A3C, {16'h0, rep[15:0]});
        frame(32'h00FF0000, 24);
        chk("short echo", 0, rep);
        frame(lw(24'h701234, 1'b1), 32);
        chk("exempt strobe", 1, {31'h0, seen_stb});
        chk("exempt crc", 0, {31'h0, crc_fault});
        frame(lw(24'h001234, 1'b1), 32);
        chk("bad crc strobe", 0, {31'h0, seen_stb});
        chk("bad crc", 1, {31'h0, crc_fault});
        frame(32'h00001234, 16);
        chk("short strobe", 0, {31'h0, seen_stb});
        chk("short count", 1, {31'h0, frame_fault});
        @(negedge sys_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        @(negedge sys_clk);
        chk("reset faults", 0, {30'h0, frame_fault, crc_fault});
        chk("reset cmd", 0, {24'h0, cmd_byte});
        crc_enable = 1'b0;
        frame(lw(24'h001234, 1'b1), 32);
        chk("crc off strobe", 1, {31'h0, seen_stb});
        chk("crc off fault", 0, {31'h0, crc_fault});
        chk("crc off data", 32'h00001234, {16'h0, cmd_data});
        finish_test();
    end
endmodule
`default_nettype wire
